// ===== eeprom_wp.sv
// Purpose: write side of a two-wire eeprom: page write, ack polling,
//   pin and config-register write protection
// Assumes: scl, sda and the protect pin are asynchronous; scl is sampled
// Notes: array page words leave through a two-entry buffer to the
//   nonvolatile store; the store commit starts at stop
// Operation
// - accept up to sixteen bytes of one row per write cycle; only the first two bytes enter the buffer, later ones are acked and dropped
// - acknowledge every data byte of a page write
// - self-timed write cycle starts at the ending stop
// - only the four low address bits increment per byte
// - in-page address wraps to page start past page end
// - no acknowledge of device address while write cycle runs
// - after write cycle, acknowledge next address and accept access
// - array accesses ignored during the write cycle
// - protect pin high protects whole array, low protects none
// - protect pin sampled at stop, later change has no effect
// - protected write still acknowledged, no cycle, ready at once
// - config access uses type 1011, bits 2:1 ignored, bit0 read select
// - config read by random read, changed by single-byte write
// - bit 3 enables software protection
// - bits 2:1 choose upper quarter, half, three quarters, all
// - bit 0 locks the config register permanently; reset here loads 00h and clears the lock
// - data bit 5 must equal written lock bit
// - abort config write if bit 6 not set or bit 5 mismatched
// - abort config write on extra bytes or when already locked
// - config read returns zeros in bits 7 to 4
// - protected ranges 300h/200h/100h/000h to 3FFh per selection
`timescale 1ns/1ps
`include "eeprom_wp_defs.svh"
module eeprom_wp
  import eeprom_wp_pkg::*;
#(
  parameter int WRITE_CYCLES = `WRITE_CYCLE_CYCLES,
  parameter logic [1:0] CHIP_SELECT = 2'h0
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic write_protect_i,
  output logic store_valid_o,
  output wr_word_t store_word_o,
  input wire logic store_ready_i,
  output logic store_commit_o,
  output logic busy_o,
  output logic [7:0] array_protection_config_o
);
  wp_state_t s;
  wp_state_t next_s;

  function automatic logic addr_protected(input logic [9:0] a,
                                          input logic [7:0] cfg);
    logic [1:0] sel;
    sel = cfg[2:1];
    if (!cfg[`CFG_ENABLE_BIT]) begin
      addr_protected = 1'b0;
    end else begin
      case (sel)
        2'h0: addr_protected = (a[9:8] == 2'h3);
        2'h1: addr_protected = a[9];
        2'h2: addr_protected = (a[9:8] != 2'h0);
        default: addr_protected = 1'b1;
      endcase
    end
  endfunction

  // device address hit: type code plus the wired chip select bit
  function automatic logic dev_hit(input logic [6:0] sh,
                                   input logic [3:0] kind);
    dev_hit = (sh[6:3] == kind) && (sh[2] == CHIP_SELECT[1]);
  endfunction

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic buf_push;
  logic buf_pop;
  logic [7:0] cfg_rd_view;

  assign scl_rise = s.scl_sync & ~s.scl_prev;
  assign scl_fall = ~s.scl_sync & s.scl_prev;
  assign start_cond = s.scl_sync & s.scl_prev & s.sda_prev & ~s.sda_sync;
  assign stop_cond = s.scl_sync & s.scl_prev & ~s.sda_prev & s.sda_sync;
  assign cfg_rd_view = {4'h0, s.config_reg[3:0]};
  assign buf_pop = store_valid_o & store_ready_i;

  always_comb begin
    next_s = s;
    buf_push = 1'b0;
    next_s.scl_meta = scl_i;
    next_s.scl_sync = s.scl_meta;
    next_s.scl_prev = s.scl_sync;
    next_s.sda_meta = sda_i;
    next_s.sda_sync = s.sda_meta;
    next_s.sda_prev = s.sda_sync;
    next_s.wp_meta = write_protect_i;
    next_s.wp_sync = s.wp_meta;
    // write cycle timer; pin changes do not touch it
    if (s.busy) begin
      if (s.wc_cnt == 32'(WRITE_CYCLES - 1)) begin
        next_s.busy = 1'b0;
      end else begin
        next_s.wc_cnt = s.wc_cnt + 32'h1;
      end
    end
    if (s.commit_pend && s.buf_cnt == 2'h0) begin
      next_s.commit_pend = 1'b0;
    end
    if (buf_pop) begin
      next_s.buf_rd = ~s.buf_rd;
    end
    if (scl_fall) begin
      if (s.ack_drive) begin
        next_s.ack_drive = 1'b0;
        next_s.sda_oe = 1'b0;
        if (s.state == ST_SKIP && s.is_read && s.is_config) begin
          // config byte leaves msb first as the address ack ends
          next_s.sda_oe = ~s.rd_data[7];
          next_s.rd_data = {s.rd_data[6:0], 1'b0};
          next_s.bit_cnt = 4'h8;
        end
      end else if (s.in_ack) begin
        next_s.sda_oe = 1'b1;
        next_s.ack_drive = 1'b1;
        next_s.in_ack = 1'b0;
      end else if (s.state == ST_SKIP && s.bit_cnt != 4'h0) begin
        next_s.bit_cnt = s.bit_cnt - 4'h1;
        if (s.bit_cnt == 4'h1) begin
          // ninth bit belongs to the host
          next_s.sda_oe = 1'b0;
        end else begin
          next_s.sda_oe = ~s.rd_data[7];
          next_s.rd_data = {s.rd_data[6:0], 1'b0};
        end
      end
    end
    if (scl_rise && s.state != ST_IDLE && s.state != ST_SKIP
        && !s.ack_drive) begin
      next_s.shift = {s.shift[6:0], s.sda_sync};
      next_s.bit_cnt = s.bit_cnt + 4'h1;
      if (s.bit_cnt == 4'h7) begin
        next_s.bit_cnt = 4'h0;
        case (s.state)
          ST_DEV: begin
            next_s.is_read = s.sda_sync;
            // bits 2 and 1 are ignored for config access
            if (!s.busy && dev_hit(s.shift[6:0], `TYPE_ARRAY)) begin
              next_s.is_config = 1'b0;
              next_s.addr[9:8] = {s.shift[1], s.shift[0]};
              next_s.in_ack = 1'b1;
              next_s.state = s.sda_sync ? ST_SKIP : ST_WORD;
            end else if (!s.busy && dev_hit(s.shift[6:0], `TYPE_CONFIG)) begin
              next_s.is_config = 1'b1;
              next_s.in_ack = 1'b1;
              next_s.rd_data = cfg_rd_view;
              next_s.state = s.sda_sync ? ST_SKIP : ST_WORD;
            end else begin
              next_s.state = ST_SKIP;
            end
          end
          ST_WORD: begin
            next_s.addr[7:0] = {s.shift[6:0], s.sda_sync};
            next_s.byte_cnt = 5'h0;
            next_s.any_protected = 1'b0;
            next_s.in_ack = 1'b1;
            next_s.state = ST_DATA;
          end
          ST_DATA: begin
            next_s.in_ack = 1'b1;
            if (s.byte_cnt != 5'h1F) begin
              next_s.byte_cnt = s.byte_cnt + 5'h1;
            end
            if (s.is_config) begin
              next_s.cfg_new = {s.shift[6:0], s.sda_sync};
            end else begin
              if (addr_protected(s.addr, s.config_reg)) begin
                next_s.any_protected = 1'b1;
              end
              if (s.buf_cnt != 2'h2 && s.byte_cnt < 5'(`PAGE_BYTES)) begin
                buf_push = 1'b1;
              end
              // low four bits wrap within the row
              next_s.addr[3:0] = s.addr[3:0] + 4'h1;
            end
          end
          default: next_s.state = ST_SKIP;
        endcase
      end
    end
    if (start_cond) begin
      next_s.state = ST_DEV;
      next_s.bit_cnt = 4'h0;
      next_s.in_ack = 1'b0;
      next_s.ack_drive = 1'b0;
      next_s.sda_oe = 1'b0;
      next_s.buf_cnt = 2'h0;
    end
    if (stop_cond) begin
      next_s.state = ST_IDLE;
      next_s.in_ack = 1'b0;
      next_s.ack_drive = 1'b0;
      next_s.sda_oe = 1'b0;
      if (s.state == ST_DATA && s.byte_cnt != 5'h0) begin
        if (s.is_config) begin
          if (s.byte_cnt == 5'h1 && !s.config_reg[`CFG_LOCK_BIT]
              && s.cfg_new[`CFG_MARK_BIT]
              && s.cfg_new[`CFG_CONFIRM_BIT] == s.cfg_new[`CFG_LOCK_BIT]) begin
            next_s.config_reg = {4'h0, s.cfg_new[3:0]};
            next_s.busy = 1'b1;
            next_s.wc_cnt = 32'h0;
          end
        end else if (s.wp_sync || s.any_protected) begin
          next_s.buf_cnt = 2'h0;
        end else begin
          next_s.busy = 1'b1;
          next_s.wc_cnt = 32'h0;
          next_s.commit_pend = 1'b1;
        end
      end
    end
    // buffer count after push/pop; a flush above wins
    if (!start_cond && !(stop_cond && next_s.buf_cnt == 2'h0
        && s.buf_cnt != 2'h0 && !next_s.commit_pend)) begin
      next_s.buf_cnt = s.buf_cnt + (buf_push ? 2'h1 : 2'h0)
                       - (buf_pop ? 2'h1 : 2'h0);
    end
    if (buf_push) begin
      next_s.buf_mem[s.buf_rd ^ s.buf_cnt[0]] = '{addr: s.addr,
        data: {s.shift[6:0], s.sda_sync}};
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.scl_meta <= 1'b1;
      s.scl_sync <= 1'b1;
      s.scl_prev <= 1'b1;
      s.sda_meta <= 1'b1;
      s.sda_sync <= 1'b1;
      s.sda_prev <= 1'b1;
      s.config_reg <= `CFG_RESET;
    end else begin
      s <= next_s;
    end
  end

  // words leave only once the stop has confirmed the write
  assign store_valid_o = s.commit_pend && s.buf_cnt != 2'h0;
  assign store_word_o = s.buf_mem[s.buf_rd];
  assign store_commit_o = s.commit_pend;
  assign sda_o = 1'b0;
  assign sda_oe_o = s.sda_oe;
  assign busy_o = s.busy;
  assign array_protection_config_o = s.config_reg;
endmodule

// ===== eeprom_wp_defs.svh
// Purpose: constants for the eeprom page write / protection block
// Assumes: 100 MHz core clock
// Notes: 8-Kbit organisation (10-bit array address)
`ifndef EEPROM_WP_DEFS_SVH
`define EEPROM_WP_DEFS_SVH
`define TYPE_ARRAY 4'hA
`define TYPE_CONFIG 4'hB
`define PAGE_BYTES 16
`define CFG_SEL_BITS 2'h3
`define CFG_ENABLE_BIT 3
`define CFG_LOCK_BIT 0
`define CFG_CONFIRM_BIT 5
`define CFG_MARK_BIT 6
`define CFG_RESET 8'h00
`define WRITE_CYCLE_TIME_US 5000
`define CLK_MHZ 100
`define WRITE_CYCLE_CYCLES (`WRITE_CYCLE_TIME_US * `CLK_MHZ)
`endif

// ===== eeprom_wp_pkg.sv
// Purpose: types for the eeprom page write / protection block
// Assumes: nothing
// Notes: none
package eeprom_wp_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DEV = 3'h1,
    ST_WORD = 3'h3,
    ST_DATA = 3'h2,
    ST_SKIP = 3'h6
  } link_state_t;
  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] data;
  } wr_word_t;
  typedef struct packed {
    logic scl_meta;
    logic scl_sync;
    logic scl_prev;
    logic sda_meta;
    logic sda_sync;
    logic sda_prev;
    logic wp_meta;
    logic wp_sync;
    link_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic in_ack;
    logic ack_drive;
    logic sda_oe;
    logic is_read;
    logic is_config;
    logic [9:0] addr;
    logic [4:0] byte_cnt;
    logic [7:0] cfg_new;
    logic any_protected;
    logic [1:0] buf_cnt;
    wr_word_t [1:0] buf_mem;
    logic buf_rd;
    logic [7:0] config_reg;
    logic busy;
    logic [31:0] wc_cnt;
    logic [7:0] rd_data;
    logic commit_pend;
  } wp_state_t;
endpackage

// ===== eeprom_wp_monitor.sv
// Purpose: port checks for eeprom_wp
// Assumes: short write cycle parameter in sim
// Notes: bind follows the module
`timescale 1ns/1ps
module eeprom_wp_monitor
  import eeprom_wp_pkg::*;
#(parameter int WRITE_CYCLES = 200) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic sda_oe_o,
  input wire logic store_valid_o,
  input wire wr_word_t store_word_o,
  input wire logic store_ready_i,
  input wire logic store_commit_o,
  input wire logic busy_o,
  input wire logic [7:0] array_protection_config_o
);
  logic [31:0] run;
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !busy_o) begin
      run <= '0;
    end else begin
      run <= run + 32'h1;
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence ack_held;
    sda_oe_o [*8];
  endsequence
  busy_len_a: assert property ($fell(busy_o) |-> run + 2 >= WRITE_CYCLES
    && run <= WRITE_CYCLES + 2) else $error("write cycle length off");
  ack_len_a: assert property ($rose(sda_oe_o) |-> ack_held)
    else $error("ack too short");
  busy_mute_a: assert property (busy_o && $past(busy_o) |->
    !$rose(sda_oe_o)) else $error("ack during write cycle");
  cfg_zero_a: assert property (array_protection_config_o[7:4] == 4'h0)
    else $error("config upper nibble set");
  lock_keep_a: assert property ($past(array_protection_config_o[0]) |->
    $stable(array_protection_config_o)) else $error("locked config changed");
  word_hold_a: assert property (store_valid_o && !store_ready_i |=>
    store_valid_o && $stable(store_word_o)) else $error("stalled word lost");
  valid_commit_a: assert property (store_valid_o |-> store_commit_o)
    else $error("store word before stop");
  cfg_busy_a: assert property ($changed(array_protection_config_o) |->
    ##[0:3] busy_o) else $error("config change without cycle");
endmodule
bind eeprom_wp eeprom_wp_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) mon (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .sda_oe_o(sda_oe_o),
  .store_valid_o(store_valid_o), .store_word_o(store_word_o),
  .store_ready_i(store_ready_i), .store_commit_o(store_commit_o),
  .busy_o(busy_o), .array_protection_config_o(array_protection_config_o));

// ===== i2c_host_model.sv
// Purpose: two-wire bus host driving the serial clock and data
// Assumes: 160 ns serial clock, pulled-up lines
// Notes: clock idles high between frames
`timescale 1ns/1ps
module i2c_host_model (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // works from idle and as a repeated start after a byte
  task automatic start();
    @(negedge clk_i);
    sda_low_o = 1'b0;
    #40 scl_o = 1'b1;
    #40 sda_low_o = 1'b1;
    #40 scl_o = 1'b0;
    #40;
  endtask
  // eight bits from the device, then a released ninth bit (no ack)
  task automatic recv(output logic [7:0] b);
    @(negedge clk_i);
    for (int i = 7; i >= -1; i--) begin
      sda_low_o = 1'b0;
      #40 scl_o = 1'b1;
      #40 if (i >= 0) b[i] = sda_i;
      #40 scl_o = 1'b0;
      #40;
    end
  endtask
  task automatic stop();
    @(negedge clk_i);
    sda_low_o = 1'b1;
    #40 scl_o = 1'b1;
    #40 sda_low_o = 1'b0;
    #80;
  endtask
  // eight bits msb first, then a released ninth bit for the ack
  task automatic send(input logic [7:0] b, output logic ack);
    @(negedge clk_i);
    for (int i = 7; i >= -1; i--) begin
      sda_low_o = (i >= 0) ? ~b[i] : 1'b0;
      #40 scl_o = 1'b1;
      #40 ack = ~sda_i;
      #40 scl_o = 1'b0;
      #40;
    end
  endtask
endmodule

// ===== eeprom_page_write_protect_bench.sv
// Purpose: self-checking bench for eeprom_wp
// Assumes: write cycle shortened to 200 clocks
// Notes: table of protection settings, then hand tests
`timescale 1ns/1ps
module eeprom_page_write_protect_bench;
  import eeprom_wp_pkg::*;
  typedef struct packed {
    logic [7:0] d;
    logic [7:0] c;
    logic [9:0] a;
    logic w;
  } row_t;
  row_t rows [12] = '{'{8'h40, 8'h00, 10'h3FF, 1'b1},
    '{8'h48, 8'h08, 10'h300, 1'b0}, '{8'h48, 8'h08, 10'h2FF, 1'b1},
    '{8'h4A, 8'h0A, 10'h200, 1'b0}, '{8'h4A, 8'h0A, 10'h1FF, 1'b1},
    '{8'h4C, 8'h0C, 10'h100, 1'b0}, '{8'h4C, 8'h0C, 10'h0FF, 1'b1},
    '{8'h4E, 8'h0E, 10'h000, 1'b0}, '{8'h0E, 8'h0E, 10'h000, 1'b0},
    '{8'h60, 8'h0E, 10'h000, 1'b0}, '{8'h61, 8'h01, 10'h3FF, 1'b1},
    '{8'h4E, 8'h01, 10'h000, 1'b1}};
  logic core_clk_i = 1'b0, rst_i = 1'b1, wp = 1'b0, rdy = 1'b1;
  logic scl, sda_low, sda_oe, valid, commit, busy, ack;
  wr_word_t word;
  logic [7:0] cfg;
  logic [7:0] rdv;
  int mismatches = 0, tests_run = 0, cycles = 0;
  wire logic sda = ~(sda_low | sda_oe);
  always #5 core_clk_i = ~core_clk_i;
  eeprom_wp #(.WRITE_CYCLES(200)) DUT (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
    .write_protect_i(wp), .store_valid_o(valid), .store_word_o(word),
    .store_ready_i(rdy), .store_commit_o(commit), .busy_o(busy),
    .array_protection_config_o(cfg));
  i2c_host_model host (.clk_i(core_clk_i), .sda_i(sda), .scl_o(scl),
    .sda_low_o(sda_low));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic put(input logic [7:0] b, input logic exp);
    host.send(b, ack);
    chk(ack, exp);
  endtask
  task automatic poll(input logic exp);
    host.start();
    put(8'hA0, exp);
    host.stop();
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    host.start();
    put({4'hA, 1'b0, a[9:8], 1'b0}, 1'b1);
    put(a[7:0], 1'b1);
    put(d, 1'b1);
    host.stop();
    repeat (10) @(negedge core_clk_i);
  endtask
  task automatic settle();
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(negedge core_clk_i);
    chk(busy, 1'b0);
  endtask
  task automatic reset();
    @(negedge core_clk_i);
    rst_i = 1'b1;
    repeat (8) @(negedge core_clk_i);
    rst_i = 1'b0;
    chk({busy, cfg}, 9'h000);
    repeat (3) @(negedge core_clk_i);
  endtask
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      stop_test();
    end
  end
  initial begin
    reset();
    foreach (rows[i]) begin
      host.start();
      put(8'hB2, 1'b1);
      put(8'hD5, 1'b1);
      put(rows[i].d, 1'b1);
      host.stop();
      settle();
      chk(cfg, rows[i].c);
      wr(rows[i].a, 8'h5A);
      chk(busy, rows[i].w);
      settle();
    end
    $display("protection table done");
    reset();
    rdy = 1'b0;
    host.start();
    put(8'hA2, 1'b1);
    put(8'h3F, 1'b1);
    put(8'h11, 1'b1);
    put(8'h22, 1'b1);
    host.stop();
    repeat (10) @(negedge core_clk_i);
    chk(busy, 1'b1);
    chk({valid, word}, {1'b1, 10'h13F, 8'h11});
    rdy = 1'b1;
    @(negedge core_clk_i);
    chk({valid, word}, {1'b1, 10'h130, 8'h22});
    poll(1'b0);
    settle();
    poll(1'b1);
    $display("page write and polling done");
    wp = 1'b1;
    wr(10'h010, 8'h33);
    chk(busy, 1'b0);
    poll(1'b1);
    wp = 1'b0;
    wr(10'h010, 8'h33);
    wp = 1'b1;
    repeat (20) @(negedge core_clk_i);
    chk(busy, 1'b1);
    settle();
    $display("protect pin done");
    wp = 1'b0;
    host.start();
    put(8'hB2, 1'b1);
    put(8'hD5, 1'b1);
    put(8'h4C, 1'b1);
    host.stop();
    settle();
    chk(cfg, 8'h0C);
    host.start();
    put(8'hB2, 1'b1);
    put(8'hD5, 1'b1);
    put(8'h48, 1'b1);
    put(8'h48, 1'b1);
    host.stop();
    repeat (10) @(negedge core_clk_i);
    chk(busy, 1'b0);
    chk(cfg, 8'h0C);
    host.start();
    put(8'hB2, 1'b1);
    put(8'hD5, 1'b1);
    host.start();
    put(8'hB3, 1'b1);
    host.recv(rdv);
    host.stop();
    chk(rdv, 8'h0C);
    $display("config read and abort done");
    stop_test();
  end
endmodule
